//--- rtl/insn_decode_if.sv
// Decoded instruction fields passed from the field decoder to the sequencer.
`timescale 1ns/100ps
`default_nettype none
interface insn_decode_if;
  import insn_decoder_pkg::*;
  insn_class_t  insn_class;
  logic [6:0]   file_addr;
  logic         dest_file;
  logic [2:0]   bit_sel;
  logic [10:0]  literal;
  logic         lit_wide;
  logic         is_skip_test;
  logic         is_branch;
  logic         writes_pc;

  modport source (output insn_class, file_addr, dest_file, bit_sel, literal, lit_wide,
                  is_skip_test, is_branch, writes_pc);
  modport sink   (input insn_class, file_addr, dest_file, bit_sel, literal, lit_wide,
                  is_skip_test, is_branch, writes_pc);
endinterface
`default_nettype wire

//--- rtl/insn_decoder_defines.svh
// Constants and field layout for the instruction word decoder.
//
// Contract
// - Every instruction is one 14-bit word of an opcode field plus operand fields.
// - Each word is classed as byte-oriented, bit-oriented or literal and control.
// - A byte-oriented operation reads or modifies the register named by its file field.
// - The file address field spans register locations 0x00 through 0x7F.
// - Destination bit 0 sends the result to the accumulator, 1 back to the file register.
// - A bit-oriented operation picks one bit of an 8-bit register by its bit select field.
// - A bit-oriented operation names the register holding that bit by its file field.
// - A literal or control operation carries an eight or eleven bit constant.
// - Don't-care bits do not change how a word decodes.
// - An instruction takes one cycle unless a test succeeds or the counter is changed; a bit-oriented op on the low counter byte takes one cycle here.
// - A taken test or counter change takes two cycles, the second one a no-operation.
// - Each instruction cycle is four consecutive oscillator periods.
`ifndef INSN_DECODER_DEFINES_SVH
`define INSN_DECODER_DEFINES_SVH

`define IW_WIDTH      14
`define IW_GROUP_HI   13
`define IW_GROUP_LO   12
`define IW_OP4_HI     11
`define IW_OP4_LO     8
`define IW_BIT_HI     9
`define IW_BIT_LO     7
`define IW_DEST_BIT   7
`define IW_FILE_HI    6
`define IW_FILE_LO    0
`define IW_K8_HI      7
`define IW_K11_HI     10
`define IW_CALLGOTO   11
`define FILE_MAX      7'h7F
`define PHASES        3'h4
`define PHASE_LAST    2'h3
`define PHASE_FIRST   2'h0
`define GRP_BYTE      2'h0
`define GRP_BIT       2'h1
`define GRP_CTL_JMP   2'h2
`define GRP_LIT       2'h3
`define BIT_BTFSC     2'h2
`define BIT_BTFSS     2'h3
`define OP_DECFSZ     4'hB
`define OP_INCFSZ     4'hF
`define OP_MISC       4'h0
`define NOP_WORD      14'h0000
`define RET_WORD      14'h0008
`define RETFIE_WORD   14'h0009
`define RETLW_OP      2'h1
`define RET_LOW       4'h8
`define RETFIE_LOW    4'h9
`define PCL_ADDR      7'h02

`endif

//--- rtl/insn_decoder_pkg.sv
// Types shared by the instruction word decoder modules.
package insn_decoder_pkg;
  typedef enum logic [1:0] {
    CLASS_BYTE    = 2'h0,
    CLASS_BIT     = 2'h1,
    CLASS_LITERAL = 2'h2
  } insn_class_t;

  typedef enum logic [1:0] {
    SEQ_RUN   = 2'h0,
    SEQ_FLUSH = 2'h1
  } seq_state_t;

  typedef struct packed {
    logic [1:0] phase;
  } phase_state_t;
endpackage

//--- rtl/insn_field_decode.sv
// Combinational split of a 14-bit instruction word into class and operand fields.
`timescale 1ns/100ps
`default_nettype none
`include "insn_decoder_defines.svh"
module insn_field_decode
  import insn_decoder_pkg::*;
(
  input  wire logic [13:0] word,
  insn_decode_if.source    dec
);
  logic [1:0] grp;
  logic [3:0] op4;

  assign grp = word[`IW_GROUP_HI:`IW_GROUP_LO];
  assign op4 = word[`IW_OP4_HI:`IW_OP4_LO];

  always_comb begin
    dec.file_addr    = word[`IW_FILE_HI:`IW_FILE_LO];
    dec.dest_file    = word[`IW_DEST_BIT];
    dec.bit_sel      = word[`IW_BIT_HI:`IW_BIT_LO];
    dec.literal      = word[`IW_K11_HI:0];
    dec.lit_wide     = 1'b0;
    dec.is_skip_test = 1'b0;
    dec.is_branch    = 1'b0;
    dec.writes_pc    = 1'b0;
    if (grp == `GRP_BYTE) begin
      dec.insn_class   = CLASS_BYTE;
      dec.is_skip_test = (op4 == `OP_DECFSZ) || (op4 == `OP_INCFSZ);
      // Any byte op that stores back into the low counter byte moves the program counter.
      dec.writes_pc    = word[`IW_DEST_BIT] && (word[`IW_FILE_HI:`IW_FILE_LO] == `PCL_ADDR);
      // Returns sit in the byte group and decode only with bits 11:4 all zero; bits 3:0 pick return or retfie.
      if (op4 == `OP_MISC && !word[`IW_DEST_BIT]) begin
        dec.is_branch = (word[3:0] == `RET_LOW) || (word[3:0] == `RETFIE_LOW);
        if (word[6:4] != 3'h0) dec.is_branch = 1'b0;
      end
    end else if (grp == `GRP_BIT) begin
      dec.insn_class   = CLASS_BIT;
      dec.is_skip_test = (word[`IW_OP4_HI:`IW_OP4_HI-1] == `BIT_BTFSC) ||
                         (word[`IW_OP4_HI:`IW_OP4_HI-1] == `BIT_BTFSS);
    end else begin
      dec.insn_class = CLASS_LITERAL;
      if (grp == `GRP_CTL_JMP) begin
        dec.lit_wide  = 1'b1;
        dec.is_branch = 1'b1;
      end else begin
        dec.literal   = {3'h0, word[`IW_K8_HI:0]};
        // Return-with-literal ignores its low opcode bits.
        dec.is_branch = (word[`IW_OP4_HI:`IW_OP4_HI-1] == `RETLW_OP);
      end
    end
  end
endmodule
`default_nettype wire

//--- rtl/insn_phase_counter.sv
// Divides the oscillator clock into four-phase instruction cycles.
`timescale 1ns/100ps
`default_nettype none
`include "insn_decoder_defines.svh"
module insn_phase_counter
  import insn_decoder_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  output logic [1:0]      phase,
  output logic            cycle_end
);
  phase_state_t state;
  phase_state_t next_state;

  always_comb begin
    next_state       = state;
    next_state.phase = state.phase + 2'h1;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) state <= '{phase: `PHASE_FIRST};
    else state <= next_state;
  end

  assign phase     = state.phase;
  assign cycle_end = (state.phase == `PHASE_LAST);

  AST_PHASE_WRAP: assert property (@(posedge core_clk) disable iff (sys_rst)
    (phase == `PHASE_LAST) |=> (phase == `PHASE_FIRST)) else $error("phase did not wrap");
endmodule
`default_nettype wire

//--- rtl/instruction_word_decoder.sv
// Top of the instruction word decoder: latches words per cycle and sequences flush cycles.
`timescale 1ns/100ps
`default_nettype none
`include "insn_decoder_defines.svh"
module instruction_word_decoder
  import insn_decoder_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic [13:0] fetch_word,
  input  wire logic        test_true,
  output logic             fetch_take,
  output logic             cycle_start,
  output logic [1:0]       osc_phase,
  output logic             exec_valid,
  output logic             exec_nop,
  output logic [1:0]       exec_class,
  output logic [6:0]       exec_file_addr,
  output logic             exec_dest_file,
  output logic [2:0]       exec_bit_sel,
  output logic [10:0]      exec_literal,
  output logic             exec_lit_wide,
  output logic             exec_branch
);
  typedef struct packed {
    seq_state_t  seq;
    logic        valid;
    logic        nop;
    logic [1:0]  cls;
    logic [6:0]  file_addr;
    logic        dest_file;
    logic [2:0]  bit_sel;
    logic [10:0] literal;
    logic        lit_wide;
    logic        branch;
    logic        skip_test;
  } top_state_t;

  top_state_t state;
  top_state_t next_state;
  logic [1:0] phase;
  logic       cycle_end;
  logic       flush_due;

  insn_decode_if dec ();

  insn_phase_counter u_phase (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .phase     (phase),
    .cycle_end (cycle_end)
  );

  insn_field_decode u_fields (
    .word (fetch_word),
    .dec  (dec)
  );

  // A second cycle is owed when the current instruction branched or its test succeeded.
  assign flush_due = state.valid && !state.nop &&
                     (state.branch || (state.skip_test && test_true));

  always_comb begin
    next_state = state;
    if (cycle_end) begin
      case (state.seq)
        SEQ_RUN: begin
          if (flush_due) begin
            next_state.seq   = SEQ_FLUSH;
            next_state.valid = 1'b1;
            next_state.nop   = 1'b1;
            next_state.branch    = 1'b0;
            next_state.skip_test = 1'b0;
          end else begin
            next_state.valid     = 1'b1;
            next_state.nop       = 1'b0;
            next_state.cls       = dec.insn_class;
            next_state.file_addr = dec.file_addr;
            next_state.dest_file = dec.dest_file;
            next_state.bit_sel   = dec.bit_sel;
            next_state.literal   = dec.literal;
            next_state.lit_wide  = dec.lit_wide;
            next_state.branch    = dec.is_branch || dec.writes_pc;
            next_state.skip_test = dec.is_skip_test;
          end
        end
        SEQ_FLUSH: begin
          next_state.seq       = SEQ_RUN;
          next_state.nop       = 1'b0;
          next_state.cls       = dec.insn_class;
          next_state.file_addr = dec.file_addr;
          next_state.dest_file = dec.dest_file;
          next_state.bit_sel   = dec.bit_sel;
          next_state.literal   = dec.literal;
          next_state.lit_wide  = dec.lit_wide;
          next_state.branch    = dec.is_branch || dec.writes_pc;
          next_state.skip_test = dec.is_skip_test;
        end
        default: next_state.seq = SEQ_RUN;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) state <= '0;
    else state <= next_state;
  end

  assign fetch_take     = cycle_end && !(state.seq == SEQ_RUN && flush_due);
  assign cycle_start    = (phase == `PHASE_FIRST);
  assign osc_phase      = phase;
  assign exec_valid     = state.valid;
  assign exec_nop       = state.nop;
  assign exec_class     = state.cls;
  assign exec_file_addr = state.file_addr;
  assign exec_dest_file = state.dest_file;
  assign exec_bit_sel   = state.bit_sel;
  assign exec_literal   = state.literal;
  assign exec_lit_wide  = state.lit_wide;
  assign exec_branch    = state.branch;

  sequence s_taken_end;
    cycle_end && state.seq == SEQ_RUN && flush_due;
  endsequence

  sequence s_nop_cycle;
    exec_nop [*4];
  endsequence

  AST_FLUSH_NOP: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_taken_end |=> s_nop_cycle) else $error("missing no-op second cycle");
  AST_SINGLE_CYCLE: assert property (@(posedge core_clk) disable iff (sys_rst)
    (cycle_end && state.seq == SEQ_RUN && !flush_due) |=> !exec_nop)
    else $error("unexpected no-op cycle");
  AST_NO_FETCH_ON_FLUSH: assert property (@(posedge core_clk) disable iff (sys_rst)
    (cycle_end && exec_valid && !exec_nop && exec_branch) |-> !fetch_take)
    else $error("word taken during flush");
  AST_FETCH_PERIOD: assert property (@(posedge core_clk) disable iff (sys_rst)
    fetch_take |=> !fetch_take [*3]) else $error("fetch faster than four periods");
  AST_FILE_FIELD: assert property (@(posedge core_clk) disable iff (sys_rst)
    (fetch_take && dec.insn_class != CLASS_LITERAL) |=>
    exec_file_addr == $past(fetch_word[6:0]) && exec_file_addr <= `FILE_MAX)
    else $error("file field wrong");
  AST_DEST_FIELD: assert property (@(posedge core_clk) disable iff (sys_rst)
    (fetch_take && dec.insn_class == CLASS_BYTE) |=> exec_dest_file == $past(fetch_word[7]))
    else $error("destination bit wrong");
  AST_BIT_FIELD: assert property (@(posedge core_clk) disable iff (sys_rst)
    (fetch_take && fetch_word[13:12] == `GRP_BIT) |=>
    exec_class == CLASS_BIT && exec_bit_sel == $past(fetch_word[9:7]))
    else $error("bit field wrong");
  AST_LIT_WIDTH: assert property (@(posedge core_clk) disable iff (sys_rst)
    (fetch_take && fetch_word[13:12] == `GRP_LIT) |=>
    !exec_lit_wide && exec_literal[10:8] == 3'h0 &&
    exec_branch == $past(fetch_word[11:10] == 2'h1))
    else $error("short literal wrong");
  AST_JUMP_WIDE: assert property (@(posedge core_clk) disable iff (sys_rst)
    (fetch_take && fetch_word[13:12] == `GRP_CTL_JMP) |=>
    exec_lit_wide && exec_branch && exec_literal == $past(fetch_word[10:0]))
    else $error("wide literal wrong");
endmodule
`default_nettype wire

//--- sim/fetch_path_model.sv
// Behavioural model of the program memory fetch path and the datapath test flag.
`timescale 1ns/100ps
`default_nettype none
module fetch_path_model (
  input  wire logic        core_clk,
  input  wire logic        fetch_take,
  input  wire logic [13:0] word_in,
  input  wire logic        test_in,
  output logic [13:0]      fetch_word,
  output logic             test_true
);
  initial begin
    fetch_word = 14'h0000;
    test_true  = 1'b0;
  end
  // Outside a fetch the bus shows the inverted word, so a latch at the wrong edge is seen.
  always @(negedge core_clk) begin
    fetch_word <= fetch_take ? word_in : ~word_in;
    test_true  <= test_in;
  end
endmodule
`default_nettype wire

//--- sim/test_instruction_word_decoder.sv
// Self-checking bench for the instruction word decoder.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin mismatches++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); end end
module test_instruction_word_decoder;
  import insn_decoder_pkg::*;
  logic        core_clk, sys_rst, test_in, test_true, fetch_take, cycle_start;
  logic        exec_valid, exec_nop, exec_dest_file, exec_lit_wide, exec_branch;
  logic [13:0] word_in, fetch_word, w;
  logic [1:0]  osc_phase, exec_class;
  logic [6:0]  exec_file_addr;
  logic [2:0]  exec_bit_sel;
  logic [10:0] exec_literal;
  logic [31:0] r;
  int          mismatches, samples_checked;
  logic [14:0] corners [12] = '{15'h4B7F, 15'h0FFF, 15'h5F85, 15'h1F85, 15'h0782,
                                15'h3455, 15'h3755, 15'h0008, 15'h2FFF, 15'h2000,
                                15'h0082, 15'h0009};

  instruction_word_decoder u_instruction_word_decoder (
    .core_clk(core_clk), .sys_rst(sys_rst), .fetch_word(fetch_word),
    .test_true(test_true), .fetch_take(fetch_take), .cycle_start(cycle_start),
    .osc_phase(osc_phase), .exec_valid(exec_valid), .exec_nop(exec_nop),
    .exec_class(exec_class), .exec_file_addr(exec_file_addr),
    .exec_dest_file(exec_dest_file), .exec_bit_sel(exec_bit_sel),
    .exec_literal(exec_literal), .exec_lit_wide(exec_lit_wide), .exec_branch(exec_branch));

  fetch_path_model u_fetch_path_model (
    .core_clk(core_clk), .fetch_take(fetch_take), .word_in(word_in),
    .test_in(test_in), .fetch_word(fetch_word), .test_true(test_true));

  task automatic test_done();
    $display("Checked %0d values, %0d mismatches", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic do_reset();
    sys_rst = 1'b1;
    repeat (2) @(negedge core_clk);
    `CHK("reset take", 1'b0, fetch_take)
    `CHK("reset valid", 1'b0, exec_valid)
    sys_rst = 1'b0;
    repeat (3) @(negedge core_clk);
    `CHK("phase", 2'h3, osc_phase)
    `CHK("first take", 1'b1, fetch_take)
    @(negedge core_clk);
  endtask

  // Issues one word when the decoder asks for it and checks its decode and timing.
  task automatic issue(input logic [13:0] iw, input logic tt);
    logic [1:0]  grp;
    logic        wide, skip, br, fl;
    logic [10:0] lit;
    grp  = iw[13:12];
    wide = (grp == 2'h2);
    lit  = wide ? iw[10:0] : {3'h0, iw[7:0]};
    skip = (grp == 2'h0 && (iw[11:8] == 4'hB || iw[11:8] == 4'hF)) || (grp == 2'h1 && iw[11]);
    br   = wide || iw[13:10] == 4'hD || (iw[13:4] == 10'h000 && iw[3:1] == 3'h4)
           || (grp == 2'h0 && iw[7] && iw[6:0] == 7'h02);
    fl   = br || (skip && tt);
    word_in = iw;
    test_in = tt;
    for (int n = 0; n < 12 && !fetch_take; n++) @(negedge core_clk);
    `CHK("asked", 1'b1, fetch_take)
    @(negedge core_clk);
    `CHK("valid", 1'b1, exec_valid)
    `CHK("start", 1'b1, cycle_start)
    `CHK("nop", 1'b0, exec_nop)
    `CHK("branch", br, exec_branch)
    if (iw[13:8] != 6'h00) begin
      `CHK("class", grp[1] ? 2'h2 : grp, exec_class)
      if (!grp[1]) `CHK("file", iw[6:0], exec_file_addr)
      if (grp == 2'h0) `CHK("dest", iw[7], exec_dest_file)
      if (grp == 2'h1) `CHK("bit", iw[9:7], exec_bit_sel)
      if (grp[1]) `CHK("literal", lit, exec_literal)
      if (grp[1]) `CHK("wide", wide, exec_lit_wide)
    end
    repeat (3) @(negedge core_clk);
    `CHK("phase3", 2'h3, osc_phase)
    `CHK("take", !fl, fetch_take)
    @(negedge core_clk);
    `CHK("flush", fl, exec_nop)
  endtask

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial begin
    #100000;
    mismatches++;
    test_done();
  end

  initial begin
    sys_rst = 1'b1;
    word_in = 14'h0000;
    test_in = 1'b0;
    mismatches = 0;
    samples_checked = 0;
    r = $urandom(32'hD352);
    do_reset();
    foreach (corners[i]) issue(corners[i][13:0], corners[i][14]);
    for (int i = 0; i < 40; i++) begin
      r = $urandom;
      w = {2'(i % 4), r[11:0]};
      if (w[13:8] == 6'h00) w[8] = 1'b1;
      issue(w, r[12]);
    end
    do_reset();
    issue(14'h0B7F, 1'b1);
    test_done();
  end
endmodule
`default_nettype wire
